// ==== core/bwpc_pkg.sv ====
// Purpose: Constants for the bus cycle control register and bus cycle timer
// Assumes: Register reached over the core's special function register port
// Notes: All offsets, fields, resets and period counts live here
package bwpc_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] BWPC_BCC_ADDR = 8'h9D;
	localparam logic [7:0] BWPC_BCC_RESET = 8'hEB;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BWPC_PFQ_BIT = 7;
	localparam int BWPC_BC_BIT = 6;
	localparam int BWPC_WRW_LO = 4;
	localparam int BWPC_RDW_LO = 2;
	localparam int BWPC_CW_LO = 0;
	// ----------------------------------------
	// Period counts
	// ----------------------------------------
	localparam logic [2:0] BWPC_DATA_BASE = 3'h4;
	localparam logic [2:0] BWPC_CODE_BASE = 3'h3;
	localparam logic [2:0] BWPC_CONST_MIN = 3'h4;
	// ----------------------------------------
	// Cycle kinds
	// ----------------------------------------
	typedef enum logic [1:0] {
		BWPC_FETCH = 2'b00,
		BWPC_CONST = 2'b01,
		BWPC_DREAD = 2'b10,
		BWPC_DWRITE = 2'b11
	} bwpc_kind_e;
	typedef enum logic [0:0] {
		BWPC_IDLE = 1'b0,
		BWPC_BUSY = 1'b1
	} bwpc_state_e;
endpackage

// ==== core/bwpc_ctrl.sv ====
// Purpose: Bus cycle control register and bus cycle length timer
// Assumes: One core clock; the core issues one bus cycle at a time
// Notes: Period count is latched at cycle start, so writes apply next cycle
`timescale 1ns/100ps
// Notes on behaviour
// - Bits 7 and 6 enable queue and cache
// - Reset leaves queue and cache enabled
// - Cache bit one enables, reset enabled
// - Write cycles last four to seven periods
// - Read cycles last four to seven periods
// - Code cycles: 01b..11b give four to six
// - Code 00b: fetch three, constant four
// - Queue stall lengthens a code cycle
// - Register at 9Dh resets to EBh
// - Same settings for every address range
// - Code fetch may be abandoned early
// - Fetch bytes to queue, others bypass
module bwpc_ctrl
	import bwpc_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Special function register port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	output logic sfr_sel,
	// Bus cycle request from the core
	input wire logic cyc_start,
	input wire logic [1:0] cyc_kind,
	input wire logic pfq_stall,
	input wire logic fetch_abort,
	input wire logic [7:0] bus_rdata,
	// Bus cycle status
	output logic cyc_busy,
	output logic cyc_done,
	output logic [2:0] cyc_periods,
	// Enables and read data routing
	output logic prefetch_queue_enable,
	output logic branch_cache_enable,
	output logic pfq_wr,
	output logic core_rd_valid,
	output logic [7:0] rd_byte
);
	// ----------------------------------------
	// Register
	// ----------------------------------------
	logic [7:0] bcc_q;
	wire hit = sfr_addr == BWPC_BCC_ADDR;
	wire bcc_we = sfr_wr && hit;
	always_ff @(posedge mclk or negedge nrst)
		if (!nrst)
			bcc_q <= BWPC_BCC_RESET;
		else if (bcc_we)
			bcc_q <= sfr_wdata;
	assign sfr_sel = hit && (sfr_rd || sfr_wr);
	assign sfr_rdata = (sfr_rd && hit) ? bcc_q : 8'h00;
	assign prefetch_queue_enable = bcc_q[BWPC_PFQ_BIT];
	assign branch_cache_enable = bcc_q[BWPC_BC_BIT];
	wire [1:0] write_wait_field = bcc_q[BWPC_WRW_LO +: 2];
	wire [1:0] read_wait_field = bcc_q[BWPC_RDW_LO +: 2];
	wire [1:0] code_wait_field = bcc_q[BWPC_CW_LO +: 2];

	// ----------------------------------------
	// Period decode, one setting for all addresses
	// ----------------------------------------
	function automatic logic [2:0] periods_of(input logic [1:0] kind, input logic [1:0] cw,
		input logic [1:0] rdw, input logic [1:0] wrw);
		logic [2:0] code;
		code = BWPC_CODE_BASE + {1'b0, cw};
		case (kind)
			BWPC_FETCH: periods_of = code;
			BWPC_CONST: periods_of = (code < BWPC_CONST_MIN) ? BWPC_CONST_MIN : code;
			BWPC_DREAD: periods_of = BWPC_DATA_BASE + {1'b0, rdw};
			BWPC_DWRITE: periods_of = BWPC_DATA_BASE + {1'b0, wrw};
			default: periods_of = BWPC_DATA_BASE;
		endcase
	endfunction
	wire [2:0] new_periods = periods_of(cyc_kind, code_wait_field, read_wait_field, write_wait_field);

	// ----------------------------------------
	// Cycle timer
	// ----------------------------------------
	bwpc_state_e state_q;
	logic [2:0] cnt_q;
	logic [1:0] kind_q;
	wire is_code = kind_q == BWPC_FETCH || kind_q == BWPC_CONST;
	wire hold = is_code && pfq_stall;
	wire last = state_q == BWPC_BUSY && cnt_q == cyc_periods && !hold;
	wire abort = state_q == BWPC_BUSY && kind_q == BWPC_FETCH && fetch_abort;
	// Count starts at one on the start edge, so busy lasts exactly the period count when the cycle is neither stalled nor aborted
	// A stall freezes the count, never the state, so abort still wins over a stall
	always_ff @(posedge mclk or negedge nrst)
		if (!nrst)
		begin
			state_q <= BWPC_IDLE;
			cnt_q <= 3'h0;
			kind_q <= 2'h0;
			cyc_periods <= 3'h0;
		end
		else
		begin
			case (state_q)
				BWPC_IDLE:
					if (cyc_start)
					begin
						state_q <= BWPC_BUSY;
						cnt_q <= 3'h1;
						kind_q <= cyc_kind;
						cyc_periods <= new_periods;
					end
				BWPC_BUSY:
					if (last || abort)
						state_q <= BWPC_IDLE;
					else if (!hold)
						cnt_q <= cnt_q + 3'h1;
				default: state_q <= BWPC_IDLE;
			endcase
		end
	assign cyc_busy = state_q == BWPC_BUSY;

	// ----------------------------------------
	// Read data routing
	// ----------------------------------------
	always_ff @(posedge mclk or negedge nrst)
		if (!nrst)
		begin
			cyc_done <= 1'b0;
			pfq_wr <= 1'b0;
			core_rd_valid <= 1'b0;
			rd_byte <= 8'h00;
		end
		else
		begin
			cyc_done <= last && !abort;
			pfq_wr <= last && !abort && kind_q == BWPC_FETCH;
			core_rd_valid <= last && (kind_q == BWPC_CONST || kind_q == BWPC_DREAD);
			if (last && kind_q != BWPC_DWRITE)
				rd_byte <= bus_rdata;
		end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	rst_enables_a: assert property (@(posedge mclk) $rose(nrst) |-> prefetch_queue_enable && branch_cache_enable)
		else $error("enables not set after reset");
	bc_bit_a: assert property (@(posedge mclk) disable iff (!nrst) branch_cache_enable == bcc_q[BWPC_BC_BIT])
		else $error("cache enable not bit 6");
	en_write_a: assert property (@(posedge mclk) disable iff (!nrst)
		bcc_we |=> prefetch_queue_enable == $past(sfr_wdata[7]) && branch_cache_enable == $past(sfr_wdata[6]))
		else $error("enable write lost");
	wr_len_a: assert property (@(posedge mclk) disable iff (!nrst) state_q == BWPC_IDLE && cyc_start
		&& cyc_kind == BWPC_DWRITE |=> cyc_periods == 3'(4 + $past(write_wait_field)))
		else $error("write period wrong");
	rd_len_a: assert property (@(posedge mclk) disable iff (!nrst) state_q == BWPC_IDLE && cyc_start
		&& cyc_kind == BWPC_DREAD |=> cyc_periods == 3'(4 + $past(read_wait_field)))
		else $error("read period wrong");
	code_len_a: assert property (@(posedge mclk) disable iff (!nrst) state_q == BWPC_IDLE && cyc_start
		&& cyc_kind == BWPC_FETCH |=> cyc_periods == 3'(3 + $past(code_wait_field)))
		else $error("code period wrong");
	const_min_a: assert property (@(posedge mclk) disable iff (!nrst) state_q == BWPC_IDLE && cyc_start
		&& cyc_kind == BWPC_CONST && code_wait_field == 2'b00 |=> cyc_periods == 3'h4)
		else $error("constant read not four");
	stall_hold_a: assert property (@(posedge mclk) disable iff (!nrst) cyc_busy && hold && !abort |=> cyc_busy)
		else $error("stall did not hold cycle");
	reg_read_a: assert property (@(posedge mclk) disable iff (!nrst) sfr_rd && sfr_addr == BWPC_BCC_ADDR
		|-> sfr_rdata == bcc_q)
		else $error("register read wrong");
	len_stable_a: assert property (@(posedge mclk) disable iff (!nrst) cyc_busy && $past(cyc_busy)
		|-> $stable(cyc_periods))
		else $error("period changed mid cycle");
	route_a: assert property (@(posedge mclk) disable iff (!nrst) !(pfq_wr && core_rd_valid))
		else $error("byte routed twice");

	// ----------------------------------------
	// Timer, routing and register checks
	// ----------------------------------------
	// Aborted fetch must leave no pulse behind, even on its last period
	abort_end_a: assert property (@(posedge mclk) disable iff (!nrst) abort
		|=> !cyc_busy && !cyc_done && !pfq_wr)
		else $error("abort left cycle running");
	fetch_queue_a: assert property (@(posedge mclk) disable iff (!nrst) last && !abort
		&& kind_q == BWPC_FETCH |=> pfq_wr && !core_rd_valid)
		else $error("fetch byte not queued");
	read_bypass_a: assert property (@(posedge mclk) disable iff (!nrst) last
		&& (kind_q == BWPC_CONST || kind_q == BWPC_DREAD) |=> core_rd_valid && !pfq_wr)
		else $error("read byte not bypassed");
	pulse_one_a: assert property (@(posedge mclk) disable iff (!nrst) cyc_done |=> !cyc_done)
		else $error("done pulse too long");
	rdbyte_keep_a: assert property (@(posedge mclk) disable iff (!nrst) !last |=> $stable(rd_byte))
		else $error("byte changed outside last period");
	// Data cycles ignore the stall input entirely
	data_nostall_a: assert property (@(posedge mclk) disable iff (!nrst) cyc_busy && !is_code && !last
		|=> cnt_q == $past(cnt_q) + 3'h1)
		else $error("data cycle count held");
	stall_count_a: assert property (@(posedge mclk) disable iff (!nrst) cyc_busy && hold && !abort
		|=> $stable(cnt_q))
		else $error("stall did not freeze count");
	busy_start_a: assert property (@(posedge mclk) disable iff (!nrst) !cyc_busy && cyc_start
		|=> cyc_busy && cnt_q == 3'h1)
		else $error("cycle did not start");
	count_max_a: assert property (@(posedge mclk) disable iff (!nrst) cyc_busy
		|-> cnt_q != 3'h0 && cnt_q <= cyc_periods)
		else $error("count beyond period");
	foreign_addr_a: assert property (@(posedge mclk) disable iff (!nrst) sfr_addr != BWPC_BCC_ADDR
		|-> sfr_rdata == 8'h00 && !sfr_sel)
		else $error("foreign address answered");
	other_write_a: assert property (@(posedge mclk) disable iff (!nrst) sfr_wr && sfr_addr != BWPC_BCC_ADDR
		|=> $stable(bcc_q))
		else $error("foreign write changed register");
	reg_keep_a: assert property (@(posedge mclk) disable iff (!nrst) !bcc_we |=> $stable(bcc_q))
		else $error("register changed without write");
	rdata_idle_a: assert property (@(posedge mclk) disable iff (!nrst) !sfr_rd |-> sfr_rdata == 8'h00)
		else $error("read data without read");
endmodule

// ==== verification/bwpc_mem_model.sv ====
// Purpose: Memory model answering core bus cycles
// Assumes: Byte is valid only while a cycle runs
// Notes: Idle bus shows the inverse, so a stale sample is caught
`timescale 1ns/100ps
module bwpc_mem_model #(parameter logic [7:0] MEM_BYTE = 8'h5A)
(
	// Core side
	input wire logic cyc_busy,
	// Read data
	output logic [7:0] bus_rdata
);
	assign bus_rdata = cyc_busy ? MEM_BYTE : ~MEM_BYTE;
endmodule

// ==== verification/test_bus_wait_prefetch_control.sv ====
// Purpose: Self-checking bench for bus cycle control
// Assumes: One bus cycle at a time, 8 ns core clock
// Notes: Counts busy cycles for every kind and wait setting
`timescale 1ns/100ps
module test_bus_wait_prefetch_control
	import bwpc_pkg::*;
();
	logic mclk = 1'b0, nrst = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, cyc_start = 1'b0;
	logic pfq_stall = 1'b0, fetch_abort = 1'b0, sfr_sel, cyc_busy, cyc_done, pfq_wr, core_rd_valid, pqe, bce;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, bus_rdata, sfr_rdata, rd_byte;
	logic [1:0] cyc_kind = 2'h0;
	logic [2:0] cyc_periods;
	int err_count = 0, n_checks = 0;
	localparam logic [7:0] MEMB = 8'h5A;
	always #4 mclk = ~mclk;
	bwpc_mem_model #(.MEM_BYTE(MEMB)) mem (.cyc_busy(cyc_busy), .bus_rdata(bus_rdata));
	bwpc_ctrl dut (.mclk(mclk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
		.sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_sel(sfr_sel), .cyc_start(cyc_start), .cyc_kind(cyc_kind),
		.pfq_stall(pfq_stall), .fetch_abort(fetch_abort), .bus_rdata(bus_rdata), .cyc_busy(cyc_busy),
		.cyc_done(cyc_done), .cyc_periods(cyc_periods), .prefetch_queue_enable(pqe),
		.branch_cache_enable(bce), .pfq_wr(pfq_wr), .core_rd_valid(core_rd_valid), .rd_byte(rd_byte));
	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge mclk);
		sfr_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		#1;
		chk(sfr_rdata, exp);
		chk({7'h0, sfr_sel}, {7'h0, a == BWPC_BCC_ADDR});
		@(posedge mclk);
		sfr_rd <= 1'b0;
	endtask
	// Stall held for st busy cycles, so the length grows by st
	task run(input logic [1:0] k, input int st, input int n);
		int c;
		c = 0;
		@(posedge mclk);
		cyc_start <= 1'b1;
		cyc_kind <= k;
		pfq_stall <= (st > 0);
		@(posedge mclk);
		cyc_start <= 1'b0;
		#1;
		while (cyc_busy === 1'b1 && c < 40)
		begin
			c++;
			if (c == st + 1)
				pfq_stall <= 1'b0;
			@(posedge mclk);
			#1;
		end
		chk(8'(c), 8'(n + st));
		chk({5'h0, cyc_periods}, 8'(n));
		chk({5'h0, cyc_done, pfq_wr, core_rd_valid}, {5'h0, 1'b1, k == 2'h0, k == 2'h1 || k == 2'h2});
		if (k != 2'h3)
			chk(rd_byte, MEMB);
	endtask
	task test_done;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
		rd(BWPC_BCC_ADDR, 8'hEB);
		chk({6'h0, pqe, bce}, 8'h03);
		rd(8'h9C, 8'h00);
		$display("test reset done");
		for (int v = 0; v < 4; v++)
		begin
			wr(BWPC_BCC_ADDR, {2'b11, 2'(v), 2'(v), 2'(v)});
			run(2'h0, 0, (v == 0) ? 3 : v + 3);
			run(2'h1, 0, v + 3 + int'(v == 0));
			run(2'h2, 0, v + 4);
			run(2'h3, 0, v + 4);
		end
		$display("test waits done");
		wr(BWPC_BCC_ADDR, 8'h3F);
		rd(BWPC_BCC_ADDR, 8'h3F);
		chk({6'h0, pqe, bce}, 8'h00);
		wr(BWPC_BCC_ADDR, 8'h80);
		#1;
		chk({6'h0, pqe, bce}, 8'h02);
		$display("test enables done");
		wr(BWPC_BCC_ADDR, 8'hC1);
		run(2'h0, 2, 4);
		run(2'h1, 2, 4);
		fork
			run(2'h2, 0, 4);
			begin
				@(posedge mclk);
				wr(BWPC_BCC_ADDR, 8'hCC);
			end
		join
		run(2'h2, 0, 7);
		wr(BWPC_BCC_ADDR, 8'hC0);
		@(posedge mclk);
		cyc_start <= 1'b1;
		cyc_kind <= 2'h0;
		@(posedge mclk);
		cyc_start <= 1'b0;
		fetch_abort <= 1'b1;
		@(posedge mclk);
		fetch_abort <= 1'b0;
		#1;
		chk({6'h0, cyc_busy, cyc_done}, 8'h00);
		@(posedge mclk);
		#1;
		chk({6'h0, cyc_done, pfq_wr}, 8'h00);
		$display("test timing done");
		test_done;
	end
	initial
	begin
		repeat (3000) @(posedge mclk);
		err_count++;
		test_done;
	end
endmodule
